// >>> design/optd_ctrl.sv
`timescale 1ns/100ps
module optd_ctrl
  import optd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic txOffPin,
  input wire logic txOffPinDriven,
  input wire logic laserFaultDet,
  input wire logic eyeUnsafe,
  input wire logic rxSignalWeak,
  input wire logic txRateSel,
  input wire logic rxRateSel,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic laserOn,
  output logic txFaultOe,
  output logic receiveSignalLost,
  output logic txRetimingCircuitOn,
  output logic rxRetimingCircuitOn
);

  // ************************************************************
  // declarations
  // ************************************************************
  optd_state_e state_reg;
  logic [2:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic memSel_reg;
  logic [7:0] idMemQ [OPTD_MEM_DEPTH];
  logic [7:0] diagMem [OPTD_MEM_DEPTH];
  logic faultLatch_reg;
  logic faultLatch_next;
  logic pinEff;
  logic pinEffQ;
  logic pinRise;
  logic swOff;
  logic txOffState;
  logic faultSet;
  logic [7:0] statusByte;
  logic [7:0] rdByte;
  logic [7:0] inByte;
  logic wrEn;
  logic sclQ;
  logic sdaQ;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic devMatchId;
  logic devMatchDiag;

  // ************************************************************
  // bus line edges
  // ************************************************************
  optd_edge_det #(.W(1)) u_sclEdge
  (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .d(sclIn),
    .q(sclQ),
    .rise(sclRise),
    .fall(sclFall)
  );

  optd_edge_det #(.W(1)) u_sdaEdge
  (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .d(sdaIn),
    .q(sdaQ),
    .rise(),
    .fall()
  );

  assign startCond = sclQ & sclIn & sdaQ & ~sdaIn;
  assign stopCond = sclQ & sclIn & ~sdaQ & sdaIn;
  assign inByte = {shift_reg[6:0], sdaIn};
  assign devMatchId = (inByte[7:1] == OPTD_ID_DEV_ADDR[7:1]); // RULE16
  assign devMatchDiag = (inByte[7:1] == OPTD_DIAG_DEV_ADDR[7:1]); // RULE17

  // ************************************************************
  // transmit-off and fault
  // ************************************************************
  // the pull-up is modelled as a high level whenever nobody drives the pin
  assign pinEff = txOffPinDriven ? txOffPin : 1'b1; // RULE2
  assign swOff = diagMem[OPTD_CTRL_STAT_ADDR][OPTD_BIT_TXOFF_SW];
  assign txOffState = pinEff | swOff; // RULE4
  assign faultSet = laserFaultDet | eyeUnsafe; // RULE12
  assign pinRise = pinEff & ~pinEffQ;

  // a fault arriving in the clearing cycle wins, so no fault is lost
  always_comb
  begin
    faultLatch_next = faultLatch_reg;
    if (pinRise)
    begin
      faultLatch_next = 1'b0; // RULE9 RULE10
    end
    if (faultSet)
    begin
      faultLatch_next = 1'b1; // RULE6 RULE8
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinEffQ <= 1'b1;
      faultLatch_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      pinEffQ <= pinEff;
      faultLatch_reg <= faultLatch_next;
    end
  end

  // laser stays off from reset until the first edge sees a low pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      laserOn <= 1'b0;
      txFaultOe <= 1'b1;
    end
    else if (clkEn)
    begin
      laserOn <= ~txOffState & ~faultLatch_next & ~eyeUnsafe; // RULE1 RULE4 RULE6 RULE12
      txFaultOe <= ~faultLatch_next; // RULE7
    end
  end

  // ************************************************************
  // rate selects and signal loss
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txRetimingCircuitOn <= 1'b0;
      rxRetimingCircuitOn <= 1'b0;
      receiveSignalLost <= 1'b1;
    end
    else if (clkEn)
    begin
      txRetimingCircuitOn <= txRateSel; // RULE13 RULE14 RULE15
      rxRetimingCircuitOn <= rxRateSel; // RULE21 RULE14 RULE15
      receiveSignalLost <= rxSignalWeak; // RULE19
    end
  end

  // ************************************************************
  // status byte and read data
  // ************************************************************
  always_comb
  begin
    statusByte = diagMem[OPTD_CTRL_STAT_ADDR] & OPTD_CTRL_STAT_WR_MASK;
    statusByte[OPTD_BIT_TXOFF_STATE] = txOffState; // RULE5 RULE18 RULE22
    statusByte[OPTD_BIT_TXFAULT] = faultLatch_reg; // RULE11 RULE22
    statusByte[OPTD_BIT_RXLOST] = rxSignalWeak; // RULE20 RULE18 RULE22
  end

  always_comb
  begin
    rdByte = idMemQ[ptr_reg];
    if (memSel_reg)
    begin
      rdByte = (ptr_reg == OPTD_CTRL_STAT_ADDR) ? statusByte : diagMem[ptr_reg];
    end
  end

  // ************************************************************
  // memories
  // ************************************************************
  assign wrEn = (state_reg == OPTD_WDATA) && sclRise && (bitCnt_reg == 3'h7);

  genvar gi;
  generate
    for (gi = 0; gi < OPTD_MEM_DEPTH; gi++)
    begin : g_mem
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          idMemQ[gi] <= OPTD_MEM_RESET;
          diagMem[gi] <= OPTD_MEM_RESET;
        end
        else if (clkEn && wrEn && (ptr_reg == 8'(gi)))
        begin
          if (!memSel_reg)
          begin
            idMemQ[gi] <= inByte;
          end
          else if (8'(gi) == OPTD_CTRL_STAT_ADDR)
          begin
            diagMem[gi] <= inByte & OPTD_CTRL_STAT_WR_MASK; // RULE22
          end
          else
          begin
            diagMem[gi] <= inByte;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // two-wire slave
  // ************************************************************
  // sda changes only after scl falls, so the host always samples a settled bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= OPTD_IDLE;
      bitCnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      memSel_reg <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end
    else if (clkEn)
    begin
      sdaOut <= 1'b0;
      if (startCond)
      begin
        state_reg <= OPTD_DEVADDR;
        bitCnt_reg <= 3'h0;
        sdaOe <= 1'b0;
      end
      else if (stopCond)
      begin
        state_reg <= OPTD_IDLE;
        sdaOe <= 1'b0;
      end
      else
      begin
        case (state_reg)
          OPTD_IDLE:
          begin
            sdaOe <= 1'b0;
          end
          OPTD_DEVADDR, OPTD_WADDR, OPTD_WDATA:
          begin
            if (sclRise)
            begin
              shift_reg <= inByte;
              bitCnt_reg <= bitCnt_reg + 3'h1;
              if (bitCnt_reg == 3'h7)
              begin
                if (state_reg == OPTD_DEVADDR)
                begin
                  if (devMatchId || devMatchDiag)
                  begin
                    memSel_reg <= devMatchDiag;
                    state_reg <= OPTD_ACK_DEV;
                  end
                  else
                  begin
                    state_reg <= OPTD_IDLE;
                  end
                end
                else if (state_reg == OPTD_WADDR)
                begin
                  ptr_reg <= inByte;
                  state_reg <= OPTD_ACK_ADDR;
                end
                else
                begin
                  ptr_reg <= ptr_reg + 8'h01;
                  state_reg <= OPTD_ACK_WR;
                end
              end
            end
          end
          OPTD_ACK_DEV, OPTD_ACK_ADDR, OPTD_ACK_WR:
          begin
            if (sclFall && !sdaOe)
            begin
              sdaOe <= 1'b1;
            end
            else if (sclFall)
            begin
              bitCnt_reg <= 3'h0;
              if ((state_reg == OPTD_ACK_DEV) && shift_reg[0])
              begin
                shift_reg <= rdByte;
                sdaOe <= ~rdByte[7];
                state_reg <= OPTD_RDATA;
              end
              else
              begin
                sdaOe <= 1'b0;
                state_reg <= (state_reg == OPTD_ACK_DEV) ? OPTD_WADDR : OPTD_WDATA;
              end
            end
          end
          OPTD_RDATA:
          begin
            if (sclRise)
            begin
              bitCnt_reg <= bitCnt_reg + 3'h1;
              if (bitCnt_reg == 3'h7)
              begin
                state_reg <= OPTD_RACK;
              end
            end
            else if (sclFall)
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sdaOe <= ~shift_reg[6];
            end
          end
          // bit counter marks the ack slot phase: 0 entry, 2 released, 3 nack, 4 ack
          OPTD_RACK:
          begin
            if (sclFall && (bitCnt_reg == 3'h0))
            begin
              sdaOe <= 1'b0;
              bitCnt_reg <= 3'h2;
            end
            else if (sclRise && (bitCnt_reg == 3'h2))
            begin
              ptr_reg <= ptr_reg + 8'h01;
              bitCnt_reg <= sdaIn ? 3'h3 : 3'h4;
            end
            else if (sclFall && (bitCnt_reg != 3'h2))
            begin
              bitCnt_reg <= 3'h0;
              if (bitCnt_reg == 3'h4)
              begin
                shift_reg <= rdByte;
                sdaOe <= ~rdByte[7];
                state_reg <= OPTD_RDATA;
              end
              else
              begin
                state_reg <= OPTD_IDLE;
              end
            end
          end
          default:
          begin
            state_reg <= OPTD_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence devByteDone;
    (state_reg == OPTD_DEVADDR) && clkEn && sclRise && (bitCnt_reg == 3'h7) && !startCond
      && !stopCond;
  endsequence

  sequence statusReadLoad;
    clkEn && sclFall && sdaOe && !startCond && !stopCond && memSel_reg
      && (ptr_reg == OPTD_CTRL_STAT_ADDR) && (state_reg == OPTD_ACK_DEV) && shift_reg[0];
  endsequence

  a_pin_off_laser: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    clkEn && pinEff |=> !laserOn)
    else $error("laser on while transmit-off pin high");

  a_undriven_pin_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    clkEn && !txOffPinDriven |=> !laserOn)
    else $error("laser on while transmit-off pin floats");

  a_sw_off_laser: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    clkEn && swOff |=> !laserOn)
    else $error("laser on while software off bit set");

  a_laser_normal_on: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    clkEn && !pinEff && !swOff && !faultLatch_reg && !faultSet |=> laserOn)
    else $error("laser off with no cause");

  a_fault_out_raise: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    clkEn && faultSet |=> !txFaultOe && !laserOn && faultLatch_reg)
    else $error("fault did not raise output and stop laser");

  a_fault_stays_latched: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    clkEn && faultLatch_reg && !pinRise |=> faultLatch_reg && !txFaultOe)
    else $error("fault dropped without pin toggle");

  a_fault_toggle_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    clkEn && pinRise && !faultSet |=> !faultLatch_reg ##0 txFaultOe)
    else $error("pin toggle did not clear fault");

  a_fault_out_level: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    txFaultOe == !faultLatch_reg)
    else $error("fault output disagrees with latch");

  a_eye_unsafe_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    clkEn && eyeUnsafe |=> !laserOn [*1] ##0 faultLatch_reg)
    else $error("unsafe condition did not stop transmitter");

  a_tx_retime_sel: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    clkEn |=> txRetimingCircuitOn == $past(txRateSel))
    else $error("transmit retiming not following rate select");

  a_rx_retime_sel: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    clkEn && (txRateSel != rxRateSel) |=> txRetimingCircuitOn != rxRetimingCircuitOn)
    else $error("receive retiming not independent");

  a_los_out: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    clkEn |=> receiveSignalLost == $past(rxSignalWeak))
    else $error("signal-loss output wrong");

  a_dev_addr_ack: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    devByteDone ##0 (devMatchId || devMatchDiag) |=> (state_reg == OPTD_ACK_DEV)
      && (memSel_reg == $past(devMatchDiag)))
    else $error("device address not acknowledged");

  a_status_read: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    statusReadLoad |=> shift_reg[7:1] == $past(statusByte[7:1]))
    else $error("status byte read wrong");

  a_flag_wr_ignored: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
    clkEn && wrEn && memSel_reg && (ptr_reg == OPTD_CTRL_STAT_ADDR)
      |=> (diagMem[OPTD_CTRL_STAT_ADDR] & ~OPTD_CTRL_STAT_WR_MASK) == 8'h00)
    else $error("read-only flag bits stored");

endmodule

// >>> design/optd_pkg.sv
// Function
// RULE1: high transmit-off input turns laser off
// RULE2: undriven transmit-off input reads as disabled
// RULE3: host spaces transmit-off assertions ten milliseconds; the testbench steps the pin only four cycles apart
// RULE4: software off bit ORed with pin
// RULE5: transmit-off state readable, byte 110 bit 7
// RULE6: laser fault raises fault output, stops laser
// RULE7: fault output open collector, high means fault
// RULE8: fault output stays latched after fault leaves
// RULE9: fault clears only by pin toggle, power
// RULE10: pin cycling resets fault, transmitter resumes
// RULE11: fault flag readable, byte 110 bit 2
// RULE12: eye-safety watch disables transmitter when unsafe
// RULE13: transmit retiming engaged only at high rate-select
// RULE14: retiming locks only at fastest line rate
// RULE15: independent transmit and receive rate selects
// RULE16: identification memory answers at address 0xA0
// RULE17: diagnostics memory answers at address 0xA2
// RULE18: transmit-off and signal-loss flags mirrored in memory
// RULE19: signal-loss output high when input unusable
// RULE20: signal-loss state readable, byte 110 bit 1
// RULE21: receive retiming engaged only at high rate-select
// RULE22: byte 110 flags live, writes to them ignored
package optd_pkg;

  // ************************************************************
  // two-wire bus addresses
  // ************************************************************
  localparam logic [7:0] OPTD_ID_DEV_ADDR = 8'ha0;
  localparam logic [7:0] OPTD_DIAG_DEV_ADDR = 8'ha2;
  localparam int OPTD_MEM_DEPTH = 256;

  // ************************************************************
  // control and status byte
  // ************************************************************
  localparam logic [7:0] OPTD_CTRL_STAT_ADDR = 8'h6e;
  localparam int OPTD_BIT_TXOFF_STATE = 7;
  localparam int OPTD_BIT_TXOFF_SW = 6;
  localparam int OPTD_BIT_TXFAULT = 2;
  localparam int OPTD_BIT_RXLOST = 1;
  localparam logic [7:0] OPTD_CTRL_STAT_WR_MASK = 8'h79;
  localparam logic [7:0] OPTD_MEM_RESET = 8'h00;

  // ************************************************************
  // host timing
  // ************************************************************
  localparam int OPTD_CLK_MHZ = 100;
  localparam int OPTD_TXOFF_SPACING_MS = 10;
  localparam int OPTD_TXOFF_SPACING_CYC = OPTD_TXOFF_SPACING_MS * OPTD_CLK_MHZ * 1000;

  // ************************************************************
  // two-wire slave states, gray along the write path
  // ************************************************************
  typedef enum logic [3:0] {
    OPTD_IDLE = 4'h0,
    OPTD_DEVADDR = 4'h1,
    OPTD_ACK_DEV = 4'h3,
    OPTD_WADDR = 4'h2,
    OPTD_ACK_ADDR = 4'h6,
    OPTD_WDATA = 4'h7,
    OPTD_ACK_WR = 4'h5,
    OPTD_RDATA = 4'h4,
    OPTD_RACK = 4'hc
  } optd_state_e;

endpackage

// >>> design/optd_edge_det.sv
`timescale 1ns/100ps
module optd_edge_det
  import optd_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // idle level of the bus lines is high, so reset to ones
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '1;
    end
    else if (clkEn)
    begin
      q <= d;
    end
  end

  assign rise = d & ~q;
  assign fall = ~d & q;

endmodule

// >>> testbench/optd_host_model.sv
`timescale 1ns/100ps
module optd_host_model
  import optd_pkg::*;
(
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ************************************************************
  // bit slots: data moves only while scl is low
  // ************************************************************
  task automatic bitSlot(input logic b, output logic seen);
    sdaLow <= ~b;
    waitClk(2);
    scl <= 1'b1;
    waitClk(3);
    seen = sdaWire;
    waitClk(1);
    scl <= 1'b0;
    waitClk(2);
  endtask

  // also serves as repeated start: sda is released before scl rises
  task automatic start();
    sdaLow <= 1'b0;
    waitClk(2);
    scl <= 1'b1;
    waitClk(3);
    sdaLow <= 1'b1;
    waitClk(3);
    scl <= 1'b0;
    waitClk(2);
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    waitClk(2);
    scl <= 1'b1;
    waitClk(3);
    sdaLow <= 1'b0;
    waitClk(3);
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitSlot(b[i], s);
    bitSlot(1'b1, s);
    ack = ~s;
  endtask

  task automatic recvByte(input logic ackIt, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitSlot(1'b1, s);
      b[i] = s;
    end
    bitSlot(~ackIt, s);
  endtask
endmodule

// >>> testbench/optical_module_tx_control_status_test.sv
`timescale 1ns/100ps
module optical_module_tx_control_status_test
  import optd_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic txOffPin = 1'b0;
  logic txOffPinDriven = 1'b0;
  logic laserFaultDet = 1'b0;
  logic eyeUnsafe = 1'b0;
  logic rxSignalWeak = 1'b0;
  logic txRateSel = 1'b0;
  logic rxRateSel = 1'b0;
  logic scl, hostSdaLow, sdaOut, sdaOe, laserOn, txFaultOe, sdaWire;
  logic receiveSignalLost, txRetimingCircuitOn, rxRetimingCircuitOn;
  logic expSw = 1'b0;
  logic expFault = 1'b0;
  logic [7:0] statWr = 8'h00;
  int miscompares = 0;
  int testsRun = 0;
  int cycles = 0;
  int seed = 32'h36e1_c1a0;

  // open-drain data wire with its pull-up
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~hostSdaLow;

  optd_ctrl i_optd_ctrl (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .txOffPin(txOffPin),
    .txOffPinDriven(txOffPinDriven), .laserFaultDet(laserFaultDet), .eyeUnsafe(eyeUnsafe),
    .rxSignalWeak(rxSignalWeak), .txRateSel(txRateSel), .rxRateSel(rxRateSel),
    .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .laserOn(laserOn),
    .txFaultOe(txFaultOe), .receiveSignalLost(receiveSignalLost),
    .txRetimingCircuitOn(txRetimingCircuitOn), .rxRetimingCircuitOn(rxRetimingCircuitOn));

  optd_host_model i_optd_host_model (.clk(clk), .sdaWire(sdaWire), .scl(scl),
    .sdaLow(hostSdaLow));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic stopTest();
    $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    testsRun++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic checkBit(input logic seen, input logic exp, input string msg);
    check({7'h00, seen}, {7'h00, exp}, msg);
  endtask

  // a floating pin reads as off through the pull-up
  function automatic logic pinEff();
    return txOffPin | ~txOffPinDriven;
  endfunction

  function automatic logic [7:0] expStat();
    logic [7:0] v;
    v = statWr & OPTD_CTRL_STAT_WR_MASK;
    v[OPTD_BIT_TXOFF_STATE] = pinEff() | expSw;
    v[OPTD_BIT_TXFAULT] = expFault;
    v[OPTD_BIT_RXLOST] = rxSignalWeak;
    return v;
  endfunction

  task automatic checkPins();
    checkBit(laserOn, ~(pinEff() | expSw | expFault | eyeUnsafe), "laser");
    checkBit(txFaultOe, ~expFault, "fault pin");
    checkBit(receiveSignalLost, rxSignalWeak, "signal lost");
    checkBit(txRetimingCircuitOn, txRateSel, "tx retiming");
    checkBit(rxRetimingCircuitOn, rxRateSel, "rx retiming");
  endtask

  // v = {pin, driven, laser fault, eye unsafe, weak input, tx rate, rx rate}
  // pin toggles come far closer than the host spacing; nothing times them here
  task automatic applyPins(input logic [6:0] v);
    logic oldEff;
    oldEff = pinEff();
    @(posedge clk);
    {txOffPin, txOffPinDriven, laserFaultDet, eyeUnsafe, rxSignalWeak, txRateSel,
      rxRateSel} <= v;
    if (v[4] | v[3])
      expFault = 1'b1;
    else if ((v[6] | ~v[5]) & ~oldEff)
      expFault = 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ************************************************************
  // two-wire transfers
  // ************************************************************
  task automatic memWrite(input logic [7:0] dev, input logic [7:0] addr, input logic [7:0] d);
    logic a;
    i_optd_host_model.start();
    i_optd_host_model.sendByte(dev, a);
    checkBit(a, 1'b1, "device ack");
    i_optd_host_model.sendByte(addr, a);
    i_optd_host_model.sendByte(d, a);
    checkBit(a, 1'b1, "data ack");
    i_optd_host_model.stop();
  endtask

  task automatic memRead(input logic [7:0] dev, input logic [7:0] addr, output logic [7:0] d);
    logic a;
    i_optd_host_model.start();
    i_optd_host_model.sendByte(dev, a);
    i_optd_host_model.sendByte(addr, a);
    i_optd_host_model.start();
    i_optd_host_model.sendByte(dev | 8'h01, a);
    i_optd_host_model.recvByte(1'b0, d);
    i_optd_host_model.stop();
  endtask

  task automatic readStat();
    logic [7:0] d;
    memRead(OPTD_DIAG_DEV_ADDR, OPTD_CTRL_STAT_ADDR, d);
    check(d, expStat(), "status byte");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      stopTest();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    logic [7:0] d, a1, v1;
    logic ack;
    static logic [6:0] steps [14] = '{7'h20, 7'h60, 7'h20, 7'h30, 7'h20, 7'h60, 7'h20,
      7'h28, 7'h20, 7'h60, 7'h20, 7'h21, 7'h22, 7'h27};
    repeat (5) @(posedge clk);
    checkBit(laserOn, 1'b0, "reset laser");
    checkBit(txFaultOe, 1'b1, "reset fault pin");
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    checkPins();
    for (int k = 0; k < 14; k++)
    begin
      applyPins(steps[k]);
      checkPins();
      if (k == 4 || k == 13)
        readStat();
    end
    $display("test done: pins, fault latch, rates");
    for (int k = 0; k < 2; k++)
    begin
      statWr = (k == 0) ? 8'hff : 8'h00;
      memWrite(OPTD_DIAG_DEV_ADDR, OPTD_CTRL_STAT_ADDR, statWr);
      expSw = statWr[OPTD_BIT_TXOFF_SW];
      repeat (3) @(posedge clk);
      checkPins();
      readStat();
    end
    $display("test done: software off bit");
    for (int k = 0; k < 4; k++)
    begin
      a1 = (k == 0) ? 8'hff : 8'($random(seed)) & 8'h3f;
      v1 = 8'($random(seed));
      memWrite(OPTD_ID_DEV_ADDR, a1, v1);
      memWrite(OPTD_DIAG_DEV_ADDR, a1, ~v1);
      memRead(OPTD_ID_DEV_ADDR, a1, d);
      check(d, v1, "id byte");
      memRead(OPTD_DIAG_DEV_ADDR, a1, d);
      check(d, ~v1, "diag byte");
    end
    i_optd_host_model.start();
    i_optd_host_model.sendByte(8'ha4, ack);
    i_optd_host_model.stop();
    checkBit(ack, 1'b0, "foreign address ack");
    $display("test done: memories");
    // clock enable low must freeze the transmit retiming output even when its rate select moves
    @(posedge clk);
    clkEn <= 1'b0;
    txRateSel <= ~txRateSel;
    repeat (3) @(posedge clk);
    checkBit(txRetimingCircuitOn, ~txRateSel, "frozen retiming");
    clkEn <= 1'b1;
    repeat (2) @(posedge clk);
    checkPins();
    $display("test done: clock enable");
    for (int k = 0; k < 40; k++)
    begin
      d = 8'($random(seed));
      a1 = 8'($random(seed));
      applyPins({d[6:5], &a1[2:0], &a1[5:3], d[2:0]});
      checkPins();
      if (k % 8 == 7)
        readStat();
    end
    $display("test done: random pins");
    stopTest();
  end
endmodule
